// ==== conversion_timing_mode_select_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module conversion_timing_mode_select_test;
  logic        mclk_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_rready_in, data_control_strap_in, shared_fs_in;
  logic        go, clash;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in;
  logic [3:0]  s_axi_wstrb_in;
  wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  wire         s_axi_rvalid_out, shared_fs_out, shared_fs_oe_n_out, shift_clk_out;
  wire         tx_filter_clock_out, rx_filter_clock_out, tx_conv_strobe_out, rx_conv_strobe_out;
  wire         rx_frame_sync_n_out, rx_serial_out, tx_end_of_data_n_out, rx_end_of_data_n_out;
  wire         general_out_hi_out, general_out_lo_out, rx_shift_busy_in;
  wire         secondary_data_in, rx_data_in, primary_active_in, secondary_active_in;
  wire [1:0]   s_axi_bresp_out, s_axi_rresp_out, serial_mode_out;
  wire [31:0]  s_axi_rdata_out;
  int          n_mismatch, n_tests;

  ctm_dsp_model dsp (.mclk_in(mclk_in), .rst_in(rst_in), .go_in(go), .clash_in(clash),
    .primary_out(primary_active_in), .secondary_out(secondary_active_in),
    .busy_out(rx_shift_busy_in), .rx_data_out(rx_data_in), .sec_data_out(secondary_data_in));
  ctm_timing uut (.*);

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_reset;
    rst_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t = 0;
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      t++;
      if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1 && t < 50);
    s_axi_bready_in <= 1'b0;
    chk(s_axi_bvalid_out, 1'b1);
    chk(s_axi_bresp_out, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t = 0;
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      t++;
      if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1 && t < 50);
    s_axi_rready_in <= 1'b0;
    chk(s_axi_rvalid_out, 1'b1);
    chk(s_axi_rdata_out, ed);
    chk(s_axi_rresp_out, er);
  endtask

  // cycles up to and including the next strobe
  task automatic gap(input bit rx, output int n);
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while ((rx ? rx_conv_strobe_out : tx_conv_strobe_out) !== 1'b1 && n < 2000);
    chk(rx ? rx_conv_strobe_out : tx_conv_strobe_out, 1'b1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] rv [0:6] = '{32'h2e4, 32'h12, 32'h1, 32'h12, 32'h12, 32'h1, 32'h12};
    for (int i = 0; i < 7; i++) rd(8'(4 * i), rv[i], 2'h0);
    rd(8'h24, 32'h0, 2'h2);
    wr(8'h24, 32'h5, 2'h2);
    wr(8'h1c, 32'h0, 2'h0);
    chk(serial_mode_out, 2'h0);
  endtask

  task automatic t_sync;
    int n, k, j;
    logic p, q;
    wr(8'h04, 32'h4, 2'h0);
    wr(8'h0c, 32'h2, 2'h0);
    wr(8'h10, 32'h3, 2'h0);
    wr(8'h18, 32'h7, 2'h0);
    repeat (3) gap(1'b0, n);
    chk(n, 16);
    chk(rx_conv_strobe_out, 1'b1);
    gap(1'b1, n);
    chk(n, 16);
    k = 0;
    j = 0;
    p = tx_filter_clock_out;
    q = shift_clk_out;
    repeat (64) begin
      @(posedge mclk_in);
      if (tx_filter_clock_out !== p) k++;
      if (shift_clk_out !== q) j++;
      if (rx_filter_clock_out !== tx_filter_clock_out) k += 100;
      p = tx_filter_clock_out;
      q = shift_clk_out;
    end
    chk(k, 16);
    chk(j, 32);
  endtask

  // codes plain, minus, plus; one period shifted by the adjust value
  task automatic t_adj(input bit rx, input int base, input int adj);
    int n, s;
    for (int c = 0; c < 3; c++) begin
      gap(rx, n);
      wr(8'h20, rx ? 32'(c << 2) : 32'(c), 2'h0);
      gap(rx, n);
      s = 0;
      repeat (3) begin
        gap(rx, n);
        s += n;
      end
      chk(s, 3 * base + (c == 2 ? adj : c == 1 ? -adj : 0));
    end
    rd(8'h20, 32'h0, 2'h0);
  endtask

  task automatic t_frame(input logic [31:0] c, input logic cl, input logic efs, input logic edr);
    wr(8'h00, c, 2'h0);
    clash <= cl;
    go <= 1'b1;
    @(posedge mclk_in);
    go <= 1'b0;
    repeat (30) @(posedge mclk_in);
    chk(shared_fs_out, 1'b1);
    chk(rx_frame_sync_n_out, 1'b0);
    repeat (80) @(posedge mclk_in);
    chk(shared_fs_out, efs);
    chk(rx_serial_out, edr);
    chk(rx_frame_sync_n_out, 1'b1);
    chk(general_out_hi_out, c[11]);
    chk(general_out_lo_out, c[10]);
    repeat (60) @(posedge mclk_in);
  endtask

  task automatic t_async;
    int n;
    wr(8'h00, 32'h284, 2'h0);
    wr(8'h14, 32'h2, 2'h0);
    wr(8'h18, 32'h2, 2'h0);
    repeat (3) gap(1'b1, n);
    chk(n, 12);
    t_adj(1'b1, 12, 2);
  endtask

  task automatic t_mode(input logic fs, input logic [1:0] em);
    int n = 0;
    data_control_strap_in <= 1'b0;
    shared_fs_in <= fs;
    do_reset;
    chk(serial_mode_out, em);
    wr(8'h00, 32'hea4, 2'h0);
    chk(general_out_hi_out, 1'b0);
    chk(shared_fs_oe_n_out, 1'b1);
    go <= 1'b1;
    @(posedge mclk_in);
    go <= 1'b0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (tx_end_of_data_n_out !== 1'b0 && n < 300);
    chk(rx_end_of_data_n_out, 1'b0);
    n = 0;
    while (tx_end_of_data_n_out === 1'b0 && n < 20) begin
      @(posedge mclk_in);
      n++;
    end
    chk(n, 4);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_in = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in, go, clash} = 4'h0;
    s_axi_awaddr_in = 8'h00;
    s_axi_araddr_in = 8'h00;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'hf;
    data_control_strap_in = 1'b1;
    shared_fs_in = 1'b1;
    n_mismatch = 0;
    n_tests = 0;
    do_reset;
    t_regs;
    t_sync;
    wr(8'h08, 32'h3, 2'h0);
    t_adj(1'b0, 16, 3);
    t_frame(32'haa4, 1'b1, 1'b0, 1'b1);
    t_frame(32'h684, 1'b1, 1'b1, 1'b0);
    t_frame(32'h284, 1'b0, 1'b0, 1'b1);
    t_async;
    t_mode(1'b1, 2'h1);
    t_mode(1'b0, 2'h2);
    tally_and_finish;
  end

  // whole run needs well under this many cycles
  initial begin
    repeat (40000) @(posedge mclk_in);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ==== ctm_defs.vh ====
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CTM_OFF_CTRL       8'h00
`define CTM_OFF_TX_PRE     8'h04
`define CTM_OFF_TX_ADJ     8'h08
`define CTM_OFF_TX_CONV    8'h0c
`define CTM_OFF_RX_PRE     8'h10
`define CTM_OFF_RX_ADJ     8'h14
`define CTM_OFF_RX_CONV    8'h18
`define CTM_OFF_STATUS     8'h1c
`define CTM_OFF_ADJ_REQ    8'h20
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTM_CTRL_SYNC_BIT  5
`define CTM_CTRL_GLO_BIT   10
`define CTM_CTRL_GHI_BIT   11
`define CTM_CTRL_RST       12'h2e4
// ----------------------------------------
// reset values of the timing registers
// ----------------------------------------
`define CTM_PRE_RST        8'h12
`define CTM_ADJ_RST        8'h01
`define CTM_CONV_RST       8'h12
// ----------------------------------------
// reload selection codes
// ----------------------------------------
`define CTM_RL_PLAIN       2'h0
`define CTM_RL_MINUS       2'h1
`define CTM_RL_PLUS        2'h2
// ----------------------------------------
// serial modes
// ----------------------------------------
`define CTM_MODE_DUAL      2'h0
`define CTM_MODE_WORD      2'h1
`define CTM_MODE_BYTE      2'h2
// ----------------------------------------
// timing counts in master clocks
// ----------------------------------------
`define CTM_SHIFT_DIV      4
`define CTM_SHIFT_HALF     1'b1
`define CTM_EOD_CYCLES     3'h4
// ----------------------------------------
// bus answers
// ----------------------------------------
`define CTM_RESP_OKAY      2'h0
`define CTM_RESP_SLVERR    2'h2
`endif

// ==== ctm_dsp_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// processor side frame model
// ----------------------------------------
module ctm_dsp_model (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic go_in,
  input  wire logic clash_in,
  output var  logic primary_out,
  output var  logic secondary_out,
  output var  logic busy_out,
  output var  logic rx_data_out,
  output var  logic sec_data_out
);
  logic [7:0] pos_reg;
  logic       tog_reg;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      pos_reg <= 8'h00;
      tog_reg <= 1'b0;
    end else begin
      tog_reg <= ~tog_reg;
      if (pos_reg != 8'h00 || go_in) begin
        pos_reg <= (pos_reg == 8'ha0) ? 8'h00 : pos_reg + 8'h01;
      end
    end
  end

  // secondary slot four shift clocks after primary ends
  // idle lines toggle so a stale level never passes
  always_comb begin
    primary_out = pos_reg >= 8'h01 && pos_reg <= 8'h40;
    secondary_out = pos_reg >= 8'h51 && pos_reg <= 8'h90;
    busy_out = secondary_out && clash_in;
    rx_data_out = (pos_reg != 8'h00) ? 1'b0 : tog_reg;
    sec_data_out = secondary_out ? 1'b1 : tog_reg;
  end
endmodule
`default_nettype wire

// ==== ctm_timing.v ====
`timescale 1ns/1ps
`default_nettype none
`include "ctm_defs.vh"
module ctm_timing (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  input  wire        data_control_strap_in,
  input  wire        shared_fs_in,
  output reg         shared_fs_out,
  output reg         shared_fs_oe_n_out,
  input  wire        secondary_data_in,
  input  wire        rx_data_in,
  input  wire        primary_active_in,
  input  wire        secondary_active_in,
  input  wire        rx_shift_busy_in,
  output reg         shift_clk_out,
  output reg         tx_filter_clock_out,
  output reg         rx_filter_clock_out,
  output reg         tx_conv_strobe_out,
  output reg         rx_conv_strobe_out,
  output reg         rx_frame_sync_n_out,
  output reg         rx_serial_out,
  output reg         tx_end_of_data_n_out,
  output reg         rx_end_of_data_n_out,
  output reg         general_out_hi_out,
  output reg         general_out_lo_out,
  output reg  [1:0]  serial_mode_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // prescale reload value, never below one so a counter cannot stall
  function [8:0] pre_load;
    input [7:0] base;
    input [7:0] adj;
    input [1:0] sel;
    reg   [8:0] v;
    begin
      v = {1'b0, base};
      if (sel == `CTM_RL_MINUS) begin
        v = (base > adj) ? {1'b0, base} - {1'b0, adj} : 9'h001;
      end else if (sel == `CTM_RL_PLUS) begin
        v = {1'b0, base} + {1'b0, adj};
      end
      if (v == 9'h000) begin
        v = 9'h001;
      end
      pre_load = v;
    end
  endfunction

  function [7:0] wr_byte;
    input [7:0] old;
    input [7:0] new_val;
    input       en;
    begin
      wr_byte = en ? new_val : old;
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [11:0] ctrl_reg;
  reg [7:0]  tx_prescale_reg;
  reg [7:0]  tx_adjust_reg;
  reg [7:0]  tx_conv_divisor_reg;
  reg [7:0]  rx_prescale_reg;
  reg [7:0]  rx_adjust_reg;
  reg [7:0]  rx_conv_divisor_reg;
  reg [1:0]  tx_sel_reg;
  reg [1:0]  rx_sel_reg;

  reg [8:0]  tx_pre_cnt_reg;
  reg [7:0]  tx_conv_cnt_reg;
  reg [8:0]  rx_pre_cnt_reg;
  reg [7:0]  rx_conv_cnt_reg;
  reg        tx_fclk_reg;
  reg        rx_fclk_reg;

  reg [1:0]  div_reg;
  reg        dc_meta_reg;
  reg        dc_sync_reg;
  reg        wb_meta_reg;
  reg        wb_sync_reg;
  reg        sd_meta_reg;
  reg        sd_sync_reg;
  reg        strap_taken_reg;
  reg        prim_d_reg;
  reg [2:0]  eod_cnt_reg;

  reg        aw_held_reg;
  reg        w_held_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;

  wire sync_mode = ctrl_reg[`CTM_CTRL_SYNC_BIT];
  wire dual_mode = (serial_mode_out == `CTM_MODE_DUAL);

  // ----------------------------------------
  // transmit chain
  // ----------------------------------------
  wire tx_pre_exp  = (tx_pre_cnt_reg <= 9'h001);
  wire tx_conv_exp = tx_pre_exp && tx_fclk_reg && (tx_conv_cnt_reg <= 8'h01);
  // adjust is consumed only at a period boundary, so it moves one conversion
  wire tx_consume  = tx_conv_exp && (tx_sel_reg != `CTM_RL_PLAIN);

  always @(posedge mclk_in) begin
    if (rst_in) begin
      tx_pre_cnt_reg     <= {1'b0, `CTM_PRE_RST};
      tx_conv_cnt_reg    <= `CTM_CONV_RST;
      tx_fclk_reg        <= 1'b0;
      tx_conv_strobe_out <= 1'b0;
    end else begin
      tx_conv_strobe_out <= tx_conv_exp;
      if (tx_pre_exp) begin
        tx_fclk_reg <= ~tx_fclk_reg;
        if (tx_conv_exp) begin
          tx_conv_cnt_reg <= tx_conv_divisor_reg;
          tx_pre_cnt_reg  <= pre_load(tx_prescale_reg, tx_adjust_reg, tx_sel_reg);
        end else begin
          tx_pre_cnt_reg <= {1'b0, tx_prescale_reg};
          if (tx_fclk_reg) begin
            tx_conv_cnt_reg <= tx_conv_cnt_reg - 8'h01;
          end
        end
      end else begin
        tx_pre_cnt_reg <= tx_pre_cnt_reg - 9'h001;
      end
    end
  end

  // ----------------------------------------
  // receive chain, held in reset while synchronous
  // ----------------------------------------
  wire rx_pre_exp  = (rx_pre_cnt_reg <= 9'h001);
  wire rx_conv_exp = rx_pre_exp && rx_fclk_reg && (rx_conv_cnt_reg <= 8'h01);
  wire rx_consume  = !sync_mode && rx_conv_exp && (rx_sel_reg != `CTM_RL_PLAIN);

  always @(posedge mclk_in) begin
    if (rst_in || sync_mode) begin
      rx_pre_cnt_reg  <= {1'b0, `CTM_PRE_RST};
      rx_conv_cnt_reg <= `CTM_CONV_RST;
      rx_fclk_reg     <= 1'b0;
    end else if (rx_pre_exp) begin
      rx_fclk_reg <= ~rx_fclk_reg;
      if (rx_conv_exp) begin
        rx_conv_cnt_reg <= rx_conv_divisor_reg;
        rx_pre_cnt_reg  <= pre_load(rx_prescale_reg, rx_adjust_reg, rx_sel_reg);
      end else begin
        rx_pre_cnt_reg <= {1'b0, rx_prescale_reg};
        if (rx_fclk_reg) begin
          rx_conv_cnt_reg <= rx_conv_cnt_reg - 8'h01;
        end
      end
    end else begin
      rx_pre_cnt_reg <= rx_pre_cnt_reg - 9'h001;
    end
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      tx_filter_clock_out <= 1'b0;
      rx_filter_clock_out <= 1'b0;
      rx_conv_strobe_out  <= 1'b0;
    end else begin
      tx_filter_clock_out <= tx_fclk_reg;
      rx_filter_clock_out <= sync_mode ? tx_fclk_reg : rx_fclk_reg;
      rx_conv_strobe_out  <= sync_mode ? tx_conv_exp : rx_conv_exp;
    end
  end

  // ----------------------------------------
  // shift clock
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (rst_in) begin
      div_reg       <= 2'h0;
      shift_clk_out <= 1'b1;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (div_reg[0] == `CTM_SHIFT_HALF) begin
        shift_clk_out <= ~shift_clk_out;
      end
    end
  end

  // ----------------------------------------
  // strap and pin synchronisers, mode decode
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (rst_in) begin
      dc_meta_reg     <= 1'b0;
      dc_sync_reg     <= 1'b0;
      wb_meta_reg     <= 1'b1;
      wb_sync_reg     <= 1'b1;
      sd_meta_reg     <= 1'b0;
      sd_sync_reg     <= 1'b0;
      strap_taken_reg <= 1'b0;
      serial_mode_out <= `CTM_MODE_WORD;
    end else begin
      dc_meta_reg <= data_control_strap_in;
      dc_sync_reg <= dc_meta_reg;
      wb_meta_reg <= shared_fs_in;
      wb_sync_reg <= wb_meta_reg;
      sd_meta_reg <= secondary_data_in;
      sd_sync_reg <= sd_meta_reg;
      // straps settle through the synchroniser before they are caught
      if (!strap_taken_reg && div_reg == 2'h3) begin
        strap_taken_reg <= 1'b1;
        if (dc_sync_reg) begin
          serial_mode_out <= `CTM_MODE_DUAL;
        end else if (wb_sync_reg) begin
          serial_mode_out <= `CTM_MODE_WORD;
        end else begin
          serial_mode_out <= `CTM_MODE_BYTE;
        end
      end
    end
  end

  // ----------------------------------------
  // frame syncs, routing, end-of-data pulses
  // ----------------------------------------
  wire sec_clash = !sync_mode && rx_shift_busy_in;
  wire sec_low   = dual_mode && secondary_active_in && !primary_active_in && !sec_clash;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      shared_fs_out        <= 1'b1;
      shared_fs_oe_n_out   <= 1'b1;
      rx_frame_sync_n_out  <= 1'b1;
      rx_serial_out        <= 1'b0;
      general_out_hi_out   <= 1'b0;
      general_out_lo_out   <= 1'b0;
      prim_d_reg           <= 1'b0;
      eod_cnt_reg          <= 3'h0;
      tx_end_of_data_n_out <= 1'b1;
      rx_end_of_data_n_out <= 1'b1;
    end else begin
      shared_fs_oe_n_out  <= ~dual_mode;
      shared_fs_out       <= ~sec_low;
      rx_frame_sync_n_out <= ~primary_active_in;
      rx_serial_out       <= sec_low ? sd_sync_reg : rx_data_in;
      general_out_hi_out  <= dual_mode & ctrl_reg[`CTM_CTRL_GHI_BIT];
      general_out_lo_out  <= dual_mode & ctrl_reg[`CTM_CTRL_GLO_BIT];
      prim_d_reg          <= primary_active_in;
      if (prim_d_reg && !primary_active_in && !dual_mode) begin
        eod_cnt_reg <= `CTM_EOD_CYCLES;
      end else if (eod_cnt_reg != 3'h0) begin
        eod_cnt_reg <= eod_cnt_reg - 3'h1;
      end
      tx_end_of_data_n_out <= ~(prim_d_reg && !primary_active_in && !dual_mode)
                              && (eod_cnt_reg <= 3'h1);
      rx_end_of_data_n_out <= ~(prim_d_reg && !primary_active_in && !dual_mode)
                              && (eod_cnt_reg <= 3'h1);
    end
  end

  // ----------------------------------------
  // bus slave, write side
  // ----------------------------------------
  wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_out;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      aw_addr_reg       <= 8'h00;
      w_data_reg        <= 32'h00000000;
      w_strb_reg        <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `CTM_RESP_OKAY;
      ctrl_reg            <= `CTM_CTRL_RST;
      tx_prescale_reg     <= `CTM_PRE_RST;
      tx_adjust_reg       <= `CTM_ADJ_RST;
      tx_conv_divisor_reg <= `CTM_CONV_RST;
      rx_prescale_reg     <= `CTM_PRE_RST;
      rx_adjust_reg       <= `CTM_ADJ_RST;
      rx_conv_divisor_reg <= `CTM_CONV_RST;
      tx_sel_reg          <= `CTM_RL_PLAIN;
      rx_sel_reg          <= `CTM_RL_PLAIN;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg       <= 1'b1;
        aw_addr_reg       <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg       <= 1'b1;
        w_data_reg       <= s_axi_wdata_in;
        w_strb_reg       <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      // a consumed adjust request clears; a new write in that cycle wins
      if (tx_consume) begin
        tx_sel_reg <= `CTM_RL_PLAIN;
      end
      if (rx_consume) begin
        rx_sel_reg <= `CTM_RL_PLAIN;
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= `CTM_RESP_OKAY;
        case (aw_addr_reg)
          `CTM_OFF_CTRL: begin
            ctrl_reg[7:0]  <= wr_byte(ctrl_reg[7:0], w_data_reg[7:0], w_strb_reg[0]);
            ctrl_reg[11:8] <= w_strb_reg[1] ? w_data_reg[11:8] : ctrl_reg[11:8];
          end
          `CTM_OFF_TX_PRE: begin
            tx_prescale_reg <= wr_byte(tx_prescale_reg, w_data_reg[7:0], w_strb_reg[0]);
          end
          `CTM_OFF_TX_ADJ: begin
            tx_adjust_reg <= wr_byte(tx_adjust_reg, w_data_reg[7:0], w_strb_reg[0]);
          end
          `CTM_OFF_TX_CONV: begin
            tx_conv_divisor_reg <= wr_byte(tx_conv_divisor_reg, w_data_reg[7:0],
                                           w_strb_reg[0]);
          end
          `CTM_OFF_RX_PRE: begin
            rx_prescale_reg <= wr_byte(rx_prescale_reg, w_data_reg[7:0], w_strb_reg[0]);
          end
          `CTM_OFF_RX_ADJ: begin
            rx_adjust_reg <= wr_byte(rx_adjust_reg, w_data_reg[7:0], w_strb_reg[0]);
          end
          `CTM_OFF_RX_CONV: begin
            rx_conv_divisor_reg <= wr_byte(rx_conv_divisor_reg, w_data_reg[7:0],
                                           w_strb_reg[0]);
          end
          `CTM_OFF_ADJ_REQ: begin
            if (w_strb_reg[0]) begin
              tx_sel_reg <= w_data_reg[1:0];
              rx_sel_reg <= w_data_reg[3:2];
            end
          end
          `CTM_OFF_STATUS: begin
          end
          default: begin
            s_axi_bresp_out <= `CTM_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        aw_held_reg       <= 1'b0;
        w_held_reg        <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // bus slave, read side
  // ----------------------------------------
  reg [31:0] rd_val;
  reg        rd_ok;

  always @* begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr_in)
      `CTM_OFF_CTRL:    rd_val[11:0] = ctrl_reg;
      `CTM_OFF_TX_PRE:  rd_val[7:0]  = tx_prescale_reg;
      `CTM_OFF_TX_ADJ:  rd_val[7:0]  = tx_adjust_reg;
      `CTM_OFF_TX_CONV: rd_val[7:0]  = tx_conv_divisor_reg;
      `CTM_OFF_RX_PRE:  rd_val[7:0]  = rx_prescale_reg;
      `CTM_OFF_RX_ADJ:  rd_val[7:0]  = rx_adjust_reg;
      `CTM_OFF_RX_CONV: rd_val[7:0]  = rx_conv_divisor_reg;
      `CTM_OFF_ADJ_REQ: rd_val[3:0]  = {rx_sel_reg, tx_sel_reg};
      `CTM_OFF_STATUS:  rd_val[15:0] = {tx_conv_cnt_reg, 3'h0, rx_fclk_reg,
                                        tx_fclk_reg, sync_mode, serial_mode_out};
      default:          rd_ok = 1'b0;
    endcase
  end

  always @(posedge mclk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `CTM_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_val;
      s_axi_rresp_out   <= rd_ok ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ==== ctm_timing_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module ctm_timing_checker (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       primary_active_in,
  input wire logic       secondary_active_in,
  input wire logic       rx_shift_busy_in,
  input wire logic       shift_clk_out,
  input wire logic       tx_conv_strobe_out,
  input wire logic       rx_conv_strobe_out,
  input wire logic       rx_frame_sync_n_out,
  input wire logic       tx_end_of_data_n_out,
  input wire logic       rx_end_of_data_n_out,
  input wire logic       shared_fs_out,
  input wire logic       shared_fs_oe_n_out,
  input wire logic       general_out_hi_out,
  input wire logic       general_out_lo_out,
  input wire logic [1:0] serial_mode_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_shift_div: assert property (
    $rose(shift_clk_out) |-> shift_clk_out[*2] ##1 !shift_clk_out[*2] ##1 shift_clk_out)
    else $error("shift clock not a divide by four");
  a_tx_strobe_one: assert property (
    tx_conv_strobe_out |=> !tx_conv_strobe_out) else $error("tx strobe wider than one cycle");
  a_rx_strobe_one: assert property (
    rx_conv_strobe_out |=> !rx_conv_strobe_out) else $error("rx strobe wider than one cycle");
  a_eod_width: assert property (
    $fell(tx_end_of_data_n_out) |-> !tx_end_of_data_n_out[*4] ##1 tx_end_of_data_n_out)
    else $error("end pulse not four cycles");
  a_eod_pair: assert property (
    $fell(tx_end_of_data_n_out) |-> $fell(rx_end_of_data_n_out)) else $error("end pulses apart");
  a_eod_cause: assert property (
    $fell(primary_active_in) && serial_mode_out != 2'h0 |-> ##[1:3] !tx_end_of_data_n_out)
    else $error("no end pulse after frame");
  a_dual_pins: assert property (
    $stable(serial_mode_out) && serial_mode_out == 2'h0
      |-> !shared_fs_oe_n_out && tx_end_of_data_n_out && rx_end_of_data_n_out)
    else $error("dual mode pin use wrong");
  a_word_pins: assert property (
    $stable(serial_mode_out) && serial_mode_out != 2'h0 |-> shared_fs_oe_n_out && shared_fs_out
      && !general_out_hi_out && !general_out_lo_out) else $error("word mode pin use wrong");
  a_fs_second: assert property (
    serial_mode_out == 2'h0 && secondary_active_in && !primary_active_in && !rx_shift_busy_in
      |=> !shared_fs_out) else $error("secondary sync missing");
  a_fs_primary: assert property (
    primary_active_in |=> shared_fs_out) else $error("secondary sync low in primary slot");
  a_rx_fs_quiet: assert property (
    secondary_active_in && !primary_active_in |=> rx_frame_sync_n_out)
    else $error("receive sync in secondary slot");

  c_tx_strobe: cover property (tx_conv_strobe_out);
  c_rx_strobe: cover property (rx_conv_strobe_out);
  c_fs_low: cover property (!shared_fs_out);
  c_eod: cover property ($fell(tx_end_of_data_n_out));
endmodule

bind ctm_timing ctm_timing_checker chk (.*);
`default_nettype wire
